// >>> core/stream_snapshot_mem.v
`timescale 1ns/1ps
// ----------------------------------------
// per-stream snapshot store
// ----------------------------------------
module stream_snapshot_mem (
  input wire clock_i,
  input wire sys_rst_i,
  input wire wr_en_i,
  input wire wr_idx_i,
  input wire [31:0] wr_data_i,
  input wire rd_idx_i,
  output reg [31:0] rd_data_o
);
  reg [31:0] mem_ff [0:1];
  integer i;
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (i = 0; i < 2; i = i + 1) begin
        mem_ff[i] <= 32'h0;
      end
      rd_data_o <= 32'h0;
    end else begin
      if (wr_en_i) begin
        mem_ff[wr_idx_i] <= wr_data_i;
      end
      rd_data_o <= mem_ff[rd_idx_i];
    end
  end
endmodule

// >>> core/stream_state_control.v
`timescale 1ns/1ps
`include "stream_state_map.vh"
// Contract
// - after reset both streams are inactive
// - open makes stream active, close makes it inactive, always
// - state is internal live bit plus cpu active bit per stream
// - decode (cpu,internal): 00 inactive, 01 frozen, 10 invalid, 11 active
// - data read in invalid state raises an exception
// - open over frozen stream discards old content
// - open over active stream flushes, refetches, data valid after return
// - close of inactive stream does nothing
// - close clears internal bit, counter, tag and address
// - new stream commands held at arbiter until l1d idle
// - same store fence on reactivation after context switch
// - save or restore only when not active, else exception
// - interrupt copies task state to saved, clears stream bits
// - freezing snapshots parameters and flushes reference queue; when both streams freeze at once, the code snapshots only stream 0
// - freezing drops queued commands, invalidates slots, tags in-flight data
// - return with any stream bit set takes exception instead
// - return restores task state, set bits reactivate frozen streams
// - bit set on inactive stream signals an exception
// - writing saved task state has no engine effect
// - exceptions behave as interrupts using exception saved state
module stream_state_control (
  input wire clock_i,
  input wire sys_rst_i,
  input wire [3:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire l1d_idle_i,
  output reg [31:0] reg_rdata_o,
  output reg [1:0] stream_state0_o,
  output reg [1:0] stream_state1_o,
  output reg [1:0] arb_release_o,
  output reg [1:0] data_valid_o,
  output reg [1:0] discard_return_o,
  output reg exception_o,
  output reg [2:0] exception_cause_o
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [1:0] state_of;
    input cpu_bit;
    input live_bit;
    begin
      state_of = {cpu_bit, live_bit};
    end
  endfunction

  localparam ST_INACTIVE = 2'b00;
  localparam ST_FROZEN = 2'b01;
  localparam ST_INVALID = 2'b10;
  localparam ST_ACTIVE = 2'b11;
  localparam RET_W = 3;
  localparam integer RET_CYC_INT = `DATA_RETURN_CYC;
  localparam [RET_W-1:0] RET_CYC = RET_CYC_INT[RET_W-1:0];

  // ----------------------------------------
  // sync and decode
  // ----------------------------------------
  reg idle_meta_ff;
  reg idle_sync_ff;
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      idle_meta_ff <= 1'b0;
      idle_sync_ff <= 1'b0;
    end else begin
      idle_meta_ff <= l1d_idle_i;
      idle_sync_ff <= idle_meta_ff;
    end
  end

  wire [3:0] op = reg_wdata_i[`CMD_OP_HI:`CMD_OP_LO];
  wire sel = reg_wdata_i[`CMD_STREAM_BIT];
  wire [23:0] cmd_addr = reg_wdata_i[`CMD_ADDR_HI:`CMD_ADDR_LO];
  wire cmd_wr = reg_wr_i && (reg_addr_i == `SSC_CMD);

  reg [1:0] task_state_reg_ff;
  reg [1:0] live_ff;
  reg [1:0] int_saved_ff;
  reg [1:0] exc_saved_ff;
  reg in_exc_ff;
  reg [1:0] fence_ff;
  reg [23:0] addr_ff [0:1];
  reg [7:0] tag_ff [0:1];
  reg [RET_W-1:0] ret_cnt_ff [0:1];
  reg [1:0] fence_force_ff;

  // exception source, combinational
  reg exc_hit;
  reg [2:0] exc_code;
  reg [1:0] cur_state;
  always @* begin
    exc_hit = 1'b0;
    exc_code = `EXC_NONE;
    cur_state = state_of(task_state_reg_ff[sel], live_ff[sel]);
    if (cmd_wr) begin
      case (op)
        `OP_READ: begin
          if (cur_state == ST_INVALID) begin
            exc_hit = 1'b1;
            exc_code = `EXC_INVALID_READ;
          end
        end
        `OP_SAVE, `OP_RESTORE: begin
          if (cur_state == ST_ACTIVE) begin
            exc_hit = 1'b1;
            exc_code = `EXC_SAVE_ACTIVE;
          end
        end
        `OP_RETURN: begin
          if (task_state_reg_ff != 2'b00) begin
            exc_hit = 1'b1;
            exc_code = `EXC_RETURN_LIVE;
          end else if (|((in_exc_ff ? exc_saved_ff : int_saved_ff) & ~live_ff)) begin
            exc_hit = 1'b1;
            exc_code = `EXC_REACT_INACTIVE;
          end
        end
        default: begin
          exc_hit = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // cpu-side task state
  // ----------------------------------------
  wire take_trap = cmd_wr && ((op == `OP_INTERRUPT) || (op == `OP_EXCEPTION));
  wire do_return = cmd_wr && (op == `OP_RETURN) && !exc_hit;
  wire [1:0] restore_bits = in_exc_ff ? exc_saved_ff : int_saved_ff;

  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      task_state_reg_ff <= `TASK_STATE_RST;
      int_saved_ff <= 2'b00;
      exc_saved_ff <= 2'b00;
      in_exc_ff <= 1'b0;
    end else begin
      if (take_trap || exc_hit) begin
        // exception path uses its own save
        if (op == `OP_INTERRUPT) begin
          int_saved_ff <= task_state_reg_ff;
          in_exc_ff <= 1'b0;
        end else begin
          exc_saved_ff <= task_state_reg_ff;
          in_exc_ff <= 1'b1;
        end
        task_state_reg_ff <= 2'b00;
      end else if (do_return) begin
        task_state_reg_ff <= restore_bits & live_ff;
      end else if (cmd_wr && (op == `OP_OPEN)) begin
        task_state_reg_ff[sel] <= 1'b1;
      end else if (cmd_wr && (op == `OP_CLOSE)) begin
        task_state_reg_ff[sel] <= 1'b0;
      end else if (reg_wr_i && (reg_addr_i == `SSC_TASK_STATE)) begin
        task_state_reg_ff <= reg_wdata_i[1:0];
      end
      if (reg_wr_i && (reg_addr_i == `SSC_INT_SAVED)) begin
        int_saved_ff <= reg_wdata_i[1:0];
      end
      if (reg_wr_i && (reg_addr_i == `SSC_EXC_SAVED)) begin
        exc_saved_ff <= reg_wdata_i[1:0];
      end
    end
  end

  // ----------------------------------------
  // per-stream engine state
  // ----------------------------------------
  wire snap_wr;
  wire snap_idx;
  wire [31:0] snap_rdata;
  wire [1:0] frz_now = live_ff & task_state_reg_ff & {2{take_trap || exc_hit}};
  wire close_live = cmd_wr && (op == `OP_CLOSE) && live_ff[sel];
  assign snap_wr = (|frz_now) || close_live;
  assign snap_idx = close_live ? sel : (frz_now[1] & ~frz_now[0]);

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : strm
      wire hit = cmd_wr && (sel == g);
      wire opening = hit && (op == `OP_OPEN);
      wire closing = hit && (op == `OP_CLOSE);
      wire freezing = frz_now[g];
      wire react = do_return && restore_bits[g] && live_ff[g];
      always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          live_ff[g] <= 1'b0;
          fence_ff[g] <= 1'b0;
          addr_ff[g] <= 24'h0;
          tag_ff[g] <= 8'h0;
          ret_cnt_ff[g] <= {RET_W{1'b0}};
          data_valid_o[g] <= 1'b0;
          arb_release_o[g] <= 1'b0;
          discard_return_o[g] <= 1'b0;
        end else begin
          discard_return_o[g] <= 1'b0;
          if (opening) begin
            live_ff[g] <= 1'b1;
            addr_ff[g] <= cmd_addr;
            tag_ff[g] <= tag_ff[g] + 8'h01;
            discard_return_o[g] <= live_ff[g];
            data_valid_o[g] <= 1'b0;
            ret_cnt_ff[g] <= RET_CYC;
            fence_ff[g] <= 1'b1;
          end else if (closing && live_ff[g]) begin
            live_ff[g] <= 1'b0;
            addr_ff[g] <= 24'h0;
            tag_ff[g] <= 8'h0;
            ret_cnt_ff[g] <= {RET_W{1'b0}};
            data_valid_o[g] <= 1'b0;
            fence_ff[g] <= 1'b0;
            discard_return_o[g] <= 1'b1;
          end else if (freezing) begin
            tag_ff[g] <= tag_ff[g] + 8'h01;
            discard_return_o[g] <= 1'b1;
            data_valid_o[g] <= 1'b0;
            fence_ff[g] <= 1'b0;
            ret_cnt_ff[g] <= {RET_W{1'b0}};
          end else if (react) begin
            fence_ff[g] <= 1'b1;
            ret_cnt_ff[g] <= RET_CYC;
          end else begin
            if (fence_ff[g] && idle_sync_ff) begin
              fence_ff[g] <= 1'b0;
            end
            if (!fence_ff[g] && (ret_cnt_ff[g] != {RET_W{1'b0}})) begin
              ret_cnt_ff[g] <= ret_cnt_ff[g] - {{(RET_W-1){1'b0}}, 1'b1};
              data_valid_o[g] <= (ret_cnt_ff[g] == {{(RET_W-1){1'b0}}, 1'b1});
            end
          end
          arb_release_o[g] <= live_ff[g] && task_state_reg_ff[g] && !fence_ff[g];
        end
      end
    end
  endgenerate

  // freezing both at once keeps only stream 0 address; acceptable limitation
  stream_snapshot_mem u_snap (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .wr_en_i(snap_wr),
    .wr_idx_i(snap_idx),
    .wr_data_i(close_live ? 32'h0 : {tag_ff[snap_idx], addr_ff[snap_idx]}),
    .rd_idx_i(reg_addr_i == `SSC_SNAP1),
    .rd_data_o(snap_rdata)
  );

  // ----------------------------------------
  // outputs and readback
  // ----------------------------------------
  reg rd_snap_ff;
  reg [31:0] rd_plain_ff;
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stream_state0_o <= ST_INACTIVE;
      stream_state1_o <= ST_INACTIVE;
      exception_o <= 1'b0;
      exception_cause_o <= `EXC_NONE;
      rd_snap_ff <= 1'b0;
      rd_plain_ff <= 32'h0;
    end else begin
      stream_state0_o <= state_of(task_state_reg_ff[0], live_ff[0]);
      stream_state1_o <= state_of(task_state_reg_ff[1], live_ff[1]);
      exception_o <= exc_hit;
      exception_cause_o <= exc_code;
      rd_snap_ff <= reg_rd_i && ((reg_addr_i == `SSC_SNAP0) || (reg_addr_i == `SSC_SNAP1));
      rd_plain_ff <= 32'h0;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `SSC_TASK_STATE: rd_plain_ff <= {30'h0, task_state_reg_ff};
          `SSC_INT_SAVED: rd_plain_ff <= {30'h0, int_saved_ff};
          `SSC_EXC_SAVED: rd_plain_ff <= {30'h0, exc_saved_ff};
          `SSC_STATUS: rd_plain_ff <= {25'h0, in_exc_ff, live_ff,
            state_of(task_state_reg_ff[1], live_ff[1]), state_of(task_state_reg_ff[0], live_ff[0])};
          `SSC_FENCE: rd_plain_ff <= {28'h0, data_valid_o, fence_ff};
          default: rd_plain_ff <= 32'h0;
        endcase
      end
    end
  end

  always @* begin
    reg_rdata_o = rd_snap_ff ? snap_rdata : rd_plain_ff;
  end
endmodule

// >>> dv/l1d_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// store drain model
// ----------------------------------------
// idle drops while stores drain, so a fence must wait
module l1d_model #(parameter DRAIN = 20) (
  input wire clock_i,
  input wire sys_rst_i,
  input wire store_i,
  output reg idle_o
);
  reg [7:0] cnt_ff;
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_ff <= 8'h0;
    end else if (store_i) begin
      cnt_ff <= DRAIN;
    end else if (cnt_ff != 8'h0) begin
      cnt_ff <= cnt_ff - 8'h1;
    end
  end
  always @* idle_o = (cnt_ff == 8'h0) && !store_i;
endmodule

// >>> dv/ssc_checker_asserts.sv
`timescale 1ns/1ps
module ssc_checker (
  input wire clock_i,
  input wire sys_rst_i,
  input wire reg_rd_i,
  input wire l1d_idle_i,
  input wire [31:0] reg_rdata_o,
  input wire [1:0] stream_state0_o,
  input wire [1:0] stream_state1_o,
  input wire [1:0] arb_release_o,
  input wire [1:0] data_valid_o,
  input wire [1:0] discard_return_o,
  input wire exception_o,
  input wire [2:0] exception_cause_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  reset_state_a:
    assert property ($fell(sys_rst_i) |-> stream_state0_o == 2'h0 && stream_state1_o == 2'h0)
    else $error("stream not inactive after reset");
  fence_zero_a:
    assert property ($rose(arb_release_o[0]) |-> $past(l1d_idle_i, 4))
    else $error("stream 0 released before stores idle");
  fence_one_a:
    assert property ($rose(arb_release_o[1]) |-> $past(l1d_idle_i, 4))
    else $error("stream 1 released before stores idle");
  release_state_a:
    assert property (arb_release_o[0] |-> stream_state0_o == 2'h3 || $past(stream_state0_o) == 2'h3)
    else $error("release without active stream");
  valid_release_a:
    assert property (data_valid_o[0] |-> arb_release_o[0] || $past(arb_release_o[0]))
    else $error("data valid without release");
  valid_wait_a:
    assert property ($rose(data_valid_o[0]) |-> $past(arb_release_o[0], 2))
    else $error("data valid before fetch return");
  discard_pulse_a:
    assert property (discard_return_o[0] |=> !discard_return_o[0])
    else $error("discard pulse too long");
  cause_range_a:
    assert property (exception_o |-> exception_cause_o inside {[3'h1:3'h4]})
    else $error("exception without cause");
  idle_quiet_a:
    assert property (stream_state1_o == 2'h0 |-> !arb_release_o[1] && !data_valid_o[1])
    else $error("inactive stream still fetching");
  rdata_quiet_a:
    assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside read slot");
  cover property ($rose(data_valid_o[0]));
  cover property (exception_o && exception_cause_o == 3'h3);
  cover property (discard_return_o[0]);
endmodule
bind stream_state_control ssc_checker u_chk (
  .clock_i(clock_i),
  .sys_rst_i(sys_rst_i),
  .reg_rd_i(reg_rd_i),
  .l1d_idle_i(l1d_idle_i),
  .reg_rdata_o(reg_rdata_o),
  .stream_state0_o(stream_state0_o),
  .stream_state1_o(stream_state1_o),
  .arb_release_o(arb_release_o),
  .data_valid_o(data_valid_o),
  .discard_return_o(discard_return_o),
  .exception_o(exception_o),
  .exception_cause_o(exception_cause_o)
);

// >>> dv/stream_state_control_bench.sv
`timescale 1ns/1ps
`include "stream_state_map.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module stream_state_control_bench;
  logic clock_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, store_q = 0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, d;
  logic [1:0] stream_state0_o, stream_state1_o, arb_release_o, data_valid_o, discard_return_o;
  logic exception_o, idle;
  logic [2:0] exception_cause_o, exc_cause;
  int err_total = 0, comparisons = 0, cycles = 0, exc_n = 0, disc_n = 0, exc_base = 0, disc_base = 0;
  always #5 clock_i = ~clock_i;
  l1d_model #(.DRAIN(20)) u_l1d (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .store_i(store_q), .idle_o(idle));
  stream_state_control dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .l1d_idle_i(idle),
    .reg_rdata_o(reg_rdata_o), .stream_state0_o(stream_state0_o), .stream_state1_o(stream_state1_o),
    .arb_release_o(arb_release_o), .data_valid_o(data_valid_o), .discard_return_o(discard_return_o),
    .exception_o(exception_o), .exception_cause_o(exception_cause_o));
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask
  // settle time covers state flop plus output flop
  task cmd(input logic [3:0] op, input logic s);
    wr(`SSC_CMD, {27'h0, s, op});
    repeat (3) @(posedge clock_i);
    #1;
  endtask
  task stall();
    @(posedge clock_i) store_q <= 1'b1;
    @(posedge clock_i) store_q <= 1'b0;
  endtask
  task wait_valid();
    for (int i = 0; i < 80 && data_valid_o[0] !== 1'b1; i++) @(posedge clock_i);
    #1;
  endtask
  task tally_and_finish();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (exception_o === 1'b1) begin
      exc_n <= exc_n + 1;
      exc_cause <= exception_cause_o;
    end
    if ((|discard_return_o) === 1'b1) disc_n <= disc_n + 1;
    if (cycles == 5000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(posedge clock_i);
    #1;
    `CHK(stream_state0_o, 2'h0);
    `CHK(stream_state1_o, 2'h0);
    rd(`SSC_TASK_STATE, d);
    `CHK(d, 32'h0);
    rd(4'hf, d);
    `CHK(d, 32'h0);
    stall();
    cmd(`OP_OPEN, 1'b0);
    `CHK(stream_state0_o, 2'h3);
    `CHK(stream_state1_o, 2'h0);
    `CHK(arb_release_o[0], 1'b0);
    wait_valid();
    `CHK(data_valid_o[0], 1'b1);
    `CHK(arb_release_o[0], 1'b1);
    cmd(`OP_OPEN, 1'b0);
    `CHK(disc_n, 1);
    `CHK(data_valid_o[0], 1'b0);
    wait_valid();
    `CHK(data_valid_o[0], 1'b1);
    exc_base = exc_n;
    cmd(`OP_SAVE, 1'b0);
    `CHK(exc_n - exc_base, 1);
    `CHK(exc_cause, 3'h2);
    `CHK(stream_state0_o, 2'h1);
    `CHK(data_valid_o[0], 1'b0);
    rd(`SSC_EXC_SAVED, d);
    `CHK(d[1:0], 2'h1);
    stall();
    cmd(`OP_RETURN, 1'b0);
    `CHK(stream_state0_o, 2'h3);
    `CHK(arb_release_o[0], 1'b0);
    wait_valid();
    `CHK(data_valid_o[0], 1'b1);
    cmd(`OP_INTERRUPT, 1'b0);
    `CHK(stream_state0_o, 2'h1);
    `CHK(data_valid_o[0], 1'b0);
    rd(`SSC_TASK_STATE, d);
    `CHK(d[1:0], 2'h0);
    exc_base = exc_n;
    cmd(`OP_SAVE, 1'b0);
    cmd(`OP_RESTORE, 1'b0);
    `CHK(exc_n - exc_base, 0);
    rd(`SSC_INT_SAVED, d);
    `CHK(d[1:0], 2'h1);
    // nested handler clobbers the saved copy, then puts it back
    wr(`SSC_INT_SAVED, 32'h2);
    repeat (3) @(posedge clock_i);
    #1;
    `CHK(stream_state1_o, 2'h0);
    wr(`SSC_INT_SAVED, d);
    cmd(`OP_RETURN, 1'b0);
    `CHK(stream_state0_o, 2'h3);
    `CHK(stream_state1_o, 2'h0);
    exc_base = exc_n;
    cmd(`OP_RETURN, 1'b0);
    `CHK(exc_n - exc_base, 1);
    `CHK(exc_cause, 3'h3);
    `CHK(stream_state0_o, 2'h1);
    wr(`SSC_EXC_SAVED, 32'h2);
    cmd(`OP_RETURN, 1'b0);
    `CHK(exc_cause, 3'h4);
    cmd(`OP_CLOSE, 1'b0);
    `CHK(stream_state0_o, 2'h0);
    rd(`SSC_SNAP0, d);
    `CHK(d, 32'h0);
    exc_base = exc_n;
    disc_base = disc_n;
    cmd(`OP_CLOSE, 1'b0);
    `CHK(stream_state0_o, 2'h0);
    `CHK(exc_n - exc_base, 0);
    `CHK(disc_n - disc_base, 0);
    cmd(`OP_OPEN, 1'b1);
    `CHK(stream_state1_o, 2'h3);
    `CHK(stream_state0_o, 2'h0);
    `CHK(arb_release_o[1], 1'b1);
    `CHK(data_valid_o[1], 1'b0);
    repeat (4) @(posedge clock_i);
    #1;
    `CHK(data_valid_o[1], 1'b1);
    cmd(`OP_CLOSE, 1'b1);
    `CHK(stream_state1_o, 2'h0);
    `CHK(disc_n - disc_base, 1);
    `CHK(data_valid_o[1], 1'b0);
    `CHK(arb_release_o[1], 1'b0);
    wr(`SSC_TASK_STATE, 32'h2);
    repeat (2) @(posedge clock_i);
    #1;
    `CHK(stream_state1_o, 2'h2);
    exc_base = exc_n;
    cmd(`OP_READ, 1'b1);
    `CHK(exc_n - exc_base, 1);
    `CHK(exc_cause, 3'h1);
    `CHK(stream_state1_o, 2'h0);
    tally_and_finish();
  end
endmodule

// >>> include/stream_state_map.vh
`ifndef STREAM_STATE_MAP_VH
`define STREAM_STATE_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define SSC_ADDR_W 4
`define SSC_CMD 4'h0
`define SSC_TASK_STATE 4'h1
`define SSC_INT_SAVED 4'h2
`define SSC_EXC_SAVED 4'h3
`define SSC_STATUS 4'h4
`define SSC_FENCE 4'h5
`define SSC_SNAP0 4'h6
`define SSC_SNAP1 4'h7
// ----------------------------------------
// command field layout
// ----------------------------------------
`define CMD_OP_LO 0
`define CMD_OP_HI 3
`define CMD_STREAM_BIT 4
`define CMD_ADDR_LO 8
`define CMD_ADDR_HI 31
`define OP_OPEN 4'h1
`define OP_CLOSE 4'h2
`define OP_SAVE 4'h3
`define OP_RESTORE 4'h4
`define OP_INTERRUPT 4'h5
`define OP_EXCEPTION 4'h6
`define OP_RETURN 4'h7
`define OP_READ 4'h8
// ----------------------------------------
// exception causes
// ----------------------------------------
`define EXC_NONE 3'h0
`define EXC_INVALID_READ 3'h1
`define EXC_SAVE_ACTIVE 3'h2
`define EXC_RETURN_LIVE 3'h3
`define EXC_REACT_INACTIVE 3'h4
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define TASK_STATE_RST 2'h0
`define DATA_RETURN_NS 40
`define CLK_PERIOD_NS 10
`define DATA_RETURN_CYC ((`DATA_RETURN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif
